// file: hdl/mwi_defines.svh
// register map, field positions, reset values and timing counts of the wake interrupt logic
`ifndef MWI_DEFINES_SVH
`define MWI_DEFINES_SVH

`define MWI_ADDR_ENABLE      8'h02
`define MWI_ADDR_PIN1_SEL    8'h0d
`define MWI_ADDR_PIN2_SEL    8'h0e
`define MWI_ADDR_PIN3_SEL    8'h0f
`define MWI_ADDR_FLAGS       8'h27

`define MWI_EN_LSB           11
`define MWI_EN_MSB           15
`define MWI_SEL_LSB          8
`define MWI_SEL_MSB          11
`define MWI_FLAG_LSB         8
`define MWI_FLAG_MSB         13
`define MWI_CHG_LEVEL_BIT    14
`define MWI_LOAD_LEVEL_BIT   15

`define MWI_SEL_INTERRUPT    4'hd
`define MWI_SEL_RESET        4'h0
`define MWI_ENABLE_RESET     5'h00
`define MWI_FLAGS_RESET      6'h00

`define MWI_CLK_PERIOD_NS    10
`define MWI_CLR_DELAY_NS     12000
`define MWI_CLR_DELAY_CYC    ((`MWI_CLR_DELAY_NS + `MWI_CLK_PERIOD_NS - 1) / `MWI_CLK_PERIOD_NS)

`endif

// file: hdl/mwi_pkg.sv
// types shared by the wake interrupt logic
package mwi_pkg;

    // msb first, in the same order as the bits of the flag register
    typedef struct packed {
        logic watchdog_warning_flag;
        logic current_high_flag;
        logic load_attach_flag;
        logic load_release_flag;
        logic charger_attach_flag;
        logic charger_release_flag;
    } mwi_flags_s;

    typedef struct packed {
        logic watchdog_warning_enable;
        logic current_rise_enable;
        logic current_release_enable;
        logic load_event_enable;
        logic charger_event_enable;
    } mwi_enables_s;

    typedef logic [3:0] mwi_sel_t;

endpackage

// file: hdl/mwi_top.sv
// wake interrupt logic: event flags, enables, clear delay and routing onto three pins
//
// Behaviour
// - load sense falling with both FETs off and load enabled sets load attach, drops pin
// - load sense rising with load enabled sets load release flag and drops pin
// - writing one clears a flag; pin returns high 12us after that write
// - current below threshold, enabled, drives pin low without any flag
// - current release interrupt ends by itself 12us after the event
// - current above threshold, enabled, sets current high flag and drops pin
// - current events only while auto current detection intermittent mode is active
// - watchdog warning, enabled, sets its flag and drops pin before expiry
// - each of three pins has a 4-bit function select field
// - select code 1101 routes the combined interrupt to that pin
// - charger enable, reset 0, gates charger flags and pin interrupt
// - load enable, reset 0, gates load flags and pin interrupt
// - current release enable, reset 0, gates the current release interrupt
// - current rise enable, reset 0, gates current high flag and interrupt
// - watchdog warning enable, reset 0, gates its flag and interrupt
// - charger release flag latches on charger sense falling, clears on write one
// - charger attach flag latches on charger sense rising, clears on write one
`timescale 1ns/1ps
`include "mwi_defines.svh"

module mwi_top #(
    parameter int CLR_DELAY_CYC = `MWI_CLR_DELAY_CYC,
    parameter int TMR_W         = 12
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        charger_sense_pin,
    input  wire logic        load_sense_pin,
    input  wire logic        charge_fet_on,
    input  wire logic        discharge_fet_on,
    input  wire logic        auto_detect_active,
    input  wire logic        current_below,
    input  wire logic        current_above,
    input  wire logic        watchdog_prewarn,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic      [2:0]  pin_int_out,
    output logic      [2:0]  pin_int_oe
);

    // refused at elaboration: a delay the counters cannot hold would wrap silently
    if (CLR_DELAY_CYC < 1 || CLR_DELAY_CYC >= (1 << TMR_W)) begin : g_bad_delay
        $error("CLR_DELAY_CYC does not fit the timer width");
    end

    // both sense pins come from outside and are synchronised first
    logic [1:0] chg_sync_q;
    logic [1:0] load_sync_q;
    logic       chg_prev_q;
    logic       load_prev_q;
    logic       below_prev_q;
    logic       above_prev_q;

    mwi_pkg::mwi_flags_s   flags_q;
    mwi_pkg::mwi_flags_s   flags_d;
    mwi_pkg::mwi_flags_s   flag_set;
    mwi_pkg::mwi_flags_s   flag_clr;
    mwi_pkg::mwi_enables_s en_q;
    mwi_pkg::mwi_sel_t     sel_q [3];
    logic [TMR_W-1:0]      hold_q;
    logic [TMR_W-1:0]      rel_q;
    logic [15:0]           rdata_q;
    logic [2:0]            pin_out_q;
    logic [2:0]            pin_oe_q;

    // edges seen on the second synchroniser stage and its delayed copy
    wire chg_rise  = chg_sync_q[1] & ~chg_prev_q;
    wire chg_fall  = ~chg_sync_q[1] & chg_prev_q;
    wire load_rise = load_sync_q[1] & ~load_prev_q;
    wire load_fall = ~load_sync_q[1] & load_prev_q;
    wire fets_off  = ~charge_fet_on & ~discharge_fet_on;
    wire below_ev  = current_below & ~below_prev_q & auto_detect_active;
    wire above_ev  = current_above & ~above_prev_q & auto_detect_active;

    // write decode
    wire wr_en_reg  = reg_wr && (reg_addr == `MWI_ADDR_ENABLE);
    wire wr_sel1    = reg_wr && (reg_addr == `MWI_ADDR_PIN1_SEL);
    wire wr_sel2    = reg_wr && (reg_addr == `MWI_ADDR_PIN2_SEL);
    wire wr_sel3    = reg_wr && (reg_addr == `MWI_ADDR_PIN3_SEL);
    wire wr_flags   = reg_wr && (reg_addr == `MWI_ADDR_FLAGS);

    assign flag_set.charger_release_flag  = chg_fall & en_q.charger_event_enable;
    assign flag_set.charger_attach_flag   = chg_rise & en_q.charger_event_enable;
    assign flag_set.load_attach_flag      = load_fall & fets_off
                                            & en_q.load_event_enable;
    assign flag_set.load_release_flag     = load_rise & en_q.load_event_enable;
    assign flag_set.current_high_flag     = above_ev & en_q.current_rise_enable;
    assign flag_set.watchdog_warning_flag = watchdog_prewarn
                                            & en_q.watchdog_warning_enable;

    assign flag_clr = wr_flags ? reg_wdata[`MWI_FLAG_MSB:`MWI_FLAG_LSB] : '0;

    // a set arriving with its own clear wins
    assign flags_d = flag_set | (flags_q & ~flag_clr);

    // a clearing write that actually drops a flag starts the clear delay
    wire clr_hit     = |(flag_clr & flags_q);
    wire rel_start   = below_ev & en_q.current_release_enable;

    // flags only count toward the pin while their source is enabled
    wire [5:0] flag_gate = {en_q.watchdog_warning_enable,
                            en_q.current_rise_enable,
                            en_q.load_event_enable,
                            en_q.load_event_enable,
                            en_q.charger_event_enable,
                            en_q.charger_event_enable};
    wire int_active = |(flags_q & flag_gate) | (rel_q != '0) | (hold_q != '0);
    wire int_out_n  = ~int_active;

    wire [2:0] routed;
    assign routed[0] = (sel_q[0] == `MWI_SEL_INTERRUPT);
    assign routed[1] = (sel_q[1] == `MWI_SEL_INTERRUPT);
    assign routed[2] = (sel_q[2] == `MWI_SEL_INTERRUPT);

    // read selection, unmapped addresses read zero
    wire [15:0] rd_enable = {en_q, {`MWI_EN_LSB{1'b0}}};
    wire [15:0] rd_flags  = {~load_sync_q[1], chg_sync_q[1], flags_q, {`MWI_FLAG_LSB{1'b0}}};
    wire [15:0] rd_mux =
        (reg_addr == `MWI_ADDR_ENABLE)   ? rd_enable :
        (reg_addr == `MWI_ADDR_PIN1_SEL) ? {4'h0, sel_q[0], 8'h00} :
        (reg_addr == `MWI_ADDR_PIN2_SEL) ? {4'h0, sel_q[1], 8'h00} :
        (reg_addr == `MWI_ADDR_PIN3_SEL) ? {4'h0, sel_q[2], 8'h00} :
        (reg_addr == `MWI_ADDR_FLAGS)    ? rd_flags : 16'h0000;

    always_ff @(posedge clk) begin
        chg_sync_q  <= {chg_sync_q[0], charger_sense_pin};
        load_sync_q <= {load_sync_q[0], load_sense_pin};
        chg_prev_q  <= chg_sync_q[1];
        load_prev_q <= load_sync_q[1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            below_prev_q <= 1'b0;
            above_prev_q <= 1'b0;
        end else begin
            below_prev_q <= current_below;
            above_prev_q <= current_above;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            en_q <= `MWI_ENABLE_RESET;
        end else if (wr_en_reg) begin
            en_q <= reg_wdata[`MWI_EN_MSB:`MWI_EN_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sel_q[0] <= `MWI_SEL_RESET;
            sel_q[1] <= `MWI_SEL_RESET;
            sel_q[2] <= `MWI_SEL_RESET;
        end else begin
            if (wr_sel1) sel_q[0] <= reg_wdata[`MWI_SEL_MSB:`MWI_SEL_LSB];
            if (wr_sel2) sel_q[1] <= reg_wdata[`MWI_SEL_MSB:`MWI_SEL_LSB];
            if (wr_sel3) sel_q[2] <= reg_wdata[`MWI_SEL_MSB:`MWI_SEL_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flags_q <= `MWI_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // the flag drops at once, the pin only after the delay
    always_ff @(posedge clk) begin
        if (reset) begin
            hold_q <= '0;
        end else if (clr_hit) begin
            hold_q <= TMR_W'(CLR_DELAY_CYC);
        end else if (hold_q != '0) begin
            hold_q <= hold_q - 1'b1;
        end
    end

    // self-clearing pulse, there is no flag to keep it
    always_ff @(posedge clk) begin
        if (reset) begin
            rel_q <= '0;
        end else if (rel_start) begin
            rel_q <= TMR_W'(CLR_DELAY_CYC);
        end else if (rel_q != '0) begin
            rel_q <= rel_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    // unrouted pins stay released so other pin functions are not disturbed
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_out_q <= 3'h7;
            pin_oe_q  <= 3'h0;
        end else begin
            pin_out_q <= ~routed | {3{int_out_n}};
            pin_oe_q  <= routed;
        end
    end

    assign reg_rdata   = rdata_q;
    assign pin_int_out = pin_out_q;
    assign pin_int_oe  = pin_oe_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_release_event;
        rel_start;
    endsequence

    sequence s_pin_low_routed;
        ##2 (!routed[0] || !pin_out_q[0]);
    endsequence

    // the last delay cycle with nothing else pending lets the routed pin go high
    sequence s_hold_expires;
        hold_q == TMR_W'(1) && !clr_hit && !rel_start && rel_q == '0;
    endsequence

    sequence s_pin0_idle;
        (flags_q & flag_gate) == '0 && routed[0];
    endsequence

    a_chg_attach_set:
        assert property (chg_rise && en_q.charger_event_enable |=> flags_q.charger_attach_flag)
        else $error("charger attach flag not set on rising charger sense");
    a_chg_release_set:
        assert property ($rose(flags_q.charger_release_flag) |-> $past(chg_fall)
                         && $past(en_q.charger_event_enable))
        else $error("charger release flag set without enabled falling edge");
    a_load_attach_set:
        assert property ($rose(flags_q.load_attach_flag) |-> $past(fets_off)
                         && $past(en_q.load_event_enable))
        else $error("load attach flag set with a FET on or disabled");
    a_load_release_set:
        assert property (load_rise && en_q.load_event_enable |=> flags_q.load_release_flag)
        else $error("load release flag not set on rising load sense");
    a_cur_high_gate:
        assert property ($rose(flags_q.current_high_flag) |-> $past(auto_detect_active)
                         && $past(en_q.current_rise_enable))
        else $error("current high flag set outside auto detection or disabled");
    a_wdt_flag_set:
        assert property (watchdog_prewarn && en_q.watchdog_warning_enable
                         |=> flags_q.watchdog_warning_flag)
        else $error("watchdog warning flag not set");
    a_release_pulse_low:
        assert property (s_release_event |-> s_pin_low_routed)
        else $error("routed pin not low after current release event");
    a_release_self_end:
        assert property (s_release_event ##1 (!rel_start)[*3]
                         |=> rel_q == TMR_W'(CLR_DELAY_CYC - 3))
        else $error("current release timer not counting down");
    a_clear_delay:
        assert property (clr_hit && !rel_start |=> hold_q == TMR_W'(CLR_DELAY_CYC)
                         && (flags_q & $past(flag_clr) & ~$past(flag_set)) == '0)
        else $error("clearing write did not drop flag and start delay");
    a_pin_unrouted_high:
        assert property (sel_q[1] != `MWI_SEL_INTERRUPT |=> pin_out_q[1] && !pin_oe_q[1])
        else $error("unrouted pin carries the interrupt");
    a_clear_pin_high:
        assert property (s_hold_expires ##1 s_pin0_idle |=> pin_out_q[0])
        else $error("routed pin not released when the clear delay ended");
    a_release_needs_auto:
        assert property (!auto_detect_active && rel_q == '0 |=> rel_q == '0)
        else $error("current release pulse started outside auto detection");
    a_release_no_flag:
        assert property (rel_start && flag_set == '0 && !wr_flags
                         |=> flags_q == $past(flags_q))
        else $error("current release event changed a flag");
    a_load_disabled:
        assert property (!en_q.load_event_enable |=> !$rose(flags_q.load_attach_flag)
                         && !$rose(flags_q.load_release_flag))
        else $error("load flag set while load events are disabled");
    a_wdt_disabled:
        assert property (!en_q.watchdog_warning_enable
                         |=> !$rose(flags_q.watchdog_warning_flag))
        else $error("watchdog warning flag set while disabled");
    a_pin_active_low:
        assert property (flags_q.current_high_flag && en_q.current_rise_enable && routed[2]
                         |=> !pin_out_q[2])
        else $error("enabled current high flag does not hold the pin low");

endmodule

// file: tb/mwi_host_line.sv
// host side of the routed interrupt pins: pull-up wired lines seen by the controller
`timescale 1ns/1ps

module mwi_host_line (
    input  wire logic [2:0] pin_int_out,
    input  wire logic [2:0] pin_int_oe,
    output logic      [2:0] int_line_n
);
    // an undriven pin floats to the controller's pull-up, never to the last driven level
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            int_line_n[i] = pin_int_oe[i] ? pin_int_out[i] : 1'b1;
        end
    end
endmodule

// file: tb/mcu_wake_interrupt_logic_test.sv
// self-checking bench for the wake interrupt logic against expected flag, register and pin values
`timescale 1ns/1ps
`include "mwi_defines.svh"
`define MWI_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module mcu_wake_interrupt_logic_test;
    localparam int CLR = 8;
    logic        clk, reset, chg_pin, load_pin, chg_fet, dis_fet, auto_on, cur_lo, cur_hi;
    logic        prewarn, reg_wr, reg_rd, hit, blk;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic [2:0]  pin_out, pin_oe, int_line;
    logic [5:0]  exp_flags;
    logic [3:0]  sel2;
    logic [4:0]  en_r;
    int          failures, cmp_count, seed;
    int          pos[7] = '{1, 0, 3, 2, 4, 5, 0};
    int          enb[7] = '{0, 0, 1, 1, 3, 4, 2};

    mwi_top #(.CLR_DELAY_CYC(CLR), .TMR_W(12)) dut (
        .clk(clk), .reset(reset), .charger_sense_pin(chg_pin), .load_sense_pin(load_pin),
        .charge_fet_on(chg_fet), .discharge_fet_on(dis_fet), .auto_detect_active(auto_on),
        .current_below(cur_lo), .current_above(cur_hi), .watchdog_prewarn(prewarn),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .pin_int_out(pin_out), .pin_int_oe(pin_oe));

    mwi_host_line host (.pin_int_out(pin_out), .pin_int_oe(pin_oe), .int_line_n(int_line));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // strobe held across one rising edge; read data is registered at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] rd);
        @(negedge clk);
        reg_wr = wr; reg_rd = !wr; reg_addr = a; reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0; reg_rd = 1'b0;
        rd = reg_rdata;
    endtask

    task automatic fire(input int k, input logic on);
        case (k)
            0: chg_pin = 1'b1;
            1: chg_pin = 1'b0;
            2: load_pin = 1'b0;
            3: load_pin = 1'b1;
            4: cur_hi = on;
            5: prewarn = on;
            default: cur_lo = on;
        endcase
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        seed = 32'h04383b90;
        {chg_pin, chg_fet, dis_fet, auto_on, cur_lo, cur_hi, prewarn, reg_wr, reg_rd} = '0;
        load_pin = 1'b1; reg_addr = 8'h00; reg_wdata = 16'h0000; exp_flags = '0;
        reset = 1'b1;
        cyc(10);
        reset = 1'b0;
        `MWI_CHK({pin_out, pin_oe}, 6'b111000)
        cyc(3);
        bus(0, `MWI_ADDR_ENABLE, 16'h0, q); `MWI_CHK(q, 16'h0000)
        bus(0, `MWI_ADDR_FLAGS, 16'h0, q); `MWI_CHK(q, 16'h0000)
        bus(1, 8'h55, 16'hffff, q);
        bus(0, 8'h55, 16'h0, q); `MWI_CHK(q, 16'h0000)
        sel2 = 4'($random(seed));
        if (sel2 == `MWI_SEL_INTERRUPT) sel2 = 4'hc;
        bus(1, `MWI_ADDR_PIN1_SEL, 16'h0d00, q);
        bus(1, `MWI_ADDR_PIN2_SEL, {4'h0, sel2, 8'h00}, q);
        bus(1, `MWI_ADDR_PIN3_SEL, 16'h0d00, q);
        bus(0, `MWI_ADDR_PIN2_SEL, 16'h0, q); `MWI_CHK(q, {4'h0, sel2, 8'h00})
        cyc(2); `MWI_CHK(pin_oe, 3'b101)
        // pass 0 all off, pass 1 all on, pass 2 charge fet on and auto detection off,
        // pass 3 random enables with the discharge fet on
        for (int p = 0; p < 4; p++) begin
            en_r = (p == 3) ? 5'($random(seed)) : ((p > 0) ? 5'h1f : 5'h00);
            bus(1, `MWI_ADDR_ENABLE, {en_r, 11'h000}, q);
            bus(0, `MWI_ADDR_ENABLE, 16'h0, q); `MWI_CHK(q, {en_r, 11'h000})
            chg_fet = (p == 2);
            dis_fet = (p == 3);
            auto_on = (p != 2);
            for (int k = 0; k < 7; k++) begin
                blk = ((p == 2) && (k == 2 || k == 4 || k == 6)) || ((p == 3) && (k == 2));
                hit = en_r[enb[k]] && !blk;
                @(negedge clk); fire(k, 1'b1);
                @(negedge clk); fire(k, 1'b0);
                cyc(5);
                `MWI_CHK(int_line, hit ? 3'b010 : 3'b111)
                if (hit && k != 6) exp_flags[pos[k]] = 1'b1;
                bus(0, `MWI_ADDR_FLAGS, 16'h0, q);
                `MWI_CHK(q, {~load_pin, chg_pin, exp_flags, 8'h00})
                if (hit && k != 6) begin
                    bus(1, `MWI_ADDR_FLAGS, (16'h0100 << pos[k]) | 16'($random(seed) & 8'hff), q);
                    exp_flags = '0;
                    cyc(CLR);
                    `MWI_CHK(int_line, 3'b010)
                    cyc(2);
                    `MWI_CHK(int_line, 3'b111)
                end
                cyc(CLR + 4);
                `MWI_CHK(int_line, 3'b111)
                bus(0, `MWI_ADDR_FLAGS, 16'h0, q); `MWI_CHK(q[13:8], exp_flags)
            end
        end
        give_verdict();
    end
endmodule
